// [core/ctd_decoder.sv]
/*
  Instruction length, cycle timing and branch resolution for a pipelined
  single-clock 8-bit controller core. Decodes one opcode with its operand bytes
  and paces the next opcode fetch.
  Assumes the fetch unit presents the opcode, both following bytes and all
  condition operands in the same cycle as OPCODE_VALID.
*/
`include "ctd_consts.svh"

// How it works
// - Code table loads via pointer or program counter: one byte, three cycles.
// - All six external data moves: one byte, three cycles.
// - Immediate load of the data pointer: three bytes, three cycles.
// - Stack push and pop of a direct byte: two bytes, two cycles.
// - Low nibble exchange swaps only low four bits; one byte, two cycles.
// - Accumulator exchange with indirect RAM two cycles; with bank register one.
// - Immediate store to indirect RAM: two bytes, two cycles.
// - Direct bit operations two bytes two cycles; carry-only ones one and one.
// - Carry jumps: two bytes, two cycles not taken, three taken.
// - Bit jumps three bytes, three or four cycles; test-and-clear clears set bit.
// - Accumulator zero jumps: two bytes, two or three cycles.
// - Compare jumps on accumulator or register: three bytes, three or four cycles.
// - Compare immediate with indirect RAM jump: four or five cycles.
// - Decrement jumps: register two bytes 2/3; direct byte three bytes 3/4.
// - Indirect jump via pointer plus accumulator: one byte, three cycles cached.
// - Taken branches, calls and returns add a stall on a target cache miss.
// - Relative offsets are signed bytes added to the following instruction address.
// - Page targets replace only the low eleven bits of the next address.
// - Long call and jump take a full sixteen bit target.
// - Direct addresses below 0x80 select RAM, 0x80 and up select special registers.
// - Indirect pointer is bank register zero or one of the current bank.
// - The unused opcode runs as a one byte, one cycle no-operation.
// - A conditional branch not taken finishes one cycle sooner than taken on a target cache hit.
// - Timing counts single system clocks with no machine cycle grouping.
module ctd_decoder
  import ctd_pkg::*;
#(
  parameter int         CYC_W        = 4,
  parameter logic [3:0] MISS_PENALTY = `CTD_MISS_PENALTY
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RST_N,
  input  wire logic             OPCODE_VALID,
  input  wire logic [7:0]       OPCODE,
  input  wire logic [7:0]       OPERAND_1,
  input  wire logic [7:0]       OPERAND_2,
  input  wire logic [15:0]      INSN_PC,
  input  wire logic [7:0]       ACC,
  input  wire logic [15:0]      DATA_POINTER,
  input  wire logic             CARRY,
  input  wire logic             BIT_VALUE,
  input  wire logic [7:0]       SRC_VALUE,
  input  wire logic [15:0]      RET_ADDR,
  input  wire logic [1:0]       BANK_SEL,
  input  wire logic             BTC_HIT,
  output logic                  READY,
  output logic [1:0]            INSN_BYTES,
  output logic [CYC_W-1:0]      INSN_CYCLES,
  output logic                  BRANCH_TAKEN,
  output logic [15:0]           BRANCH_TARGET,
  output logic [15:0]           NEXT_PC,
  output logic                  CACHE_MISS,
  output logic                  BIT_CLEAR,
  output logic                  DIRECT_SPECIAL,
  output logic [7:0]            INDIRECT_PTR_ADDR,
  output logic [7:0]            NIBBLE_ACC,
  output logic [7:0]            NIBBLE_RAM
);

  function automatic ctd_dec_t mk(input logic [1:0] b, input logic [3:0] c,
                                  input ctd_kind_t k, input ctd_tgt_t t);
    mk = '{bytes: b, cyc: c, kind: k, tgt: t};
  endfunction

  function automatic ctd_dec_t decode(input logic [7:0] op);
    decode = mk(2'h1, 4'h1, CTD_K_SEQ, CTD_T_NONE);
    casez (op)
      8'h00, 8'hA5:                    decode = mk(2'h1, 4'h1, CTD_K_SEQ, CTD_T_NONE);
      8'b???0_0001, 8'b???1_0001:      decode = mk(2'h2, 4'h3, CTD_K_JUMP, CTD_T_PAGE);
      8'h02, 8'h12:                    decode = mk(2'h3, 4'h4, CTD_K_JUMP, CTD_T_FULL);
      8'h22, 8'h32:                    decode = mk(2'h1, 4'h5, CTD_K_RET, CTD_T_RET);
      8'h73:                           decode = mk(2'h1, 4'h3, CTD_K_IND, CTD_T_IND);
      8'h80:                           decode = mk(2'h2, 4'h3, CTD_K_JUMP, CTD_T_REL);
      8'h10:                           decode = mk(2'h3, 4'h3, CTD_K_BC, CTD_T_REL);
      8'h20:                           decode = mk(2'h3, 4'h3, CTD_K_B, CTD_T_REL);
      8'h30:                           decode = mk(2'h3, 4'h3, CTD_K_NB, CTD_T_REL);
      8'h40:                           decode = mk(2'h2, 4'h2, CTD_K_C, CTD_T_REL);
      8'h50:                           decode = mk(2'h2, 4'h2, CTD_K_NC, CTD_T_REL);
      8'h60:                           decode = mk(2'h2, 4'h2, CTD_K_Z, CTD_T_REL);
      8'h70:                           decode = mk(2'h2, 4'h2, CTD_K_NZ, CTD_T_REL);
      8'hB4, 8'hB5, 8'b1011_1???:      decode = mk(2'h3, 4'h3, CTD_K_NE, CTD_T_REL);
      8'b1011_011?:                    decode = mk(2'h3, 4'h4, CTD_K_NE, CTD_T_REL);
      8'hD5:                           decode = mk(2'h3, 4'h3, CTD_K_DJ, CTD_T_REL);
      8'b1101_1???:                    decode = mk(2'h2, 4'h2, CTD_K_DJ, CTD_T_REL);
      8'h83, 8'h93:                    decode = mk(2'h1, 4'h3, CTD_K_SEQ, CTD_T_NONE);
      8'hE0, 8'hF0, 8'b111?_001?:      decode = mk(2'h1, 4'h3, CTD_K_SEQ, CTD_T_NONE);
      8'h90:                           decode = mk(2'h3, 4'h3, CTD_K_SEQ, CTD_T_NONE);
      8'h84:                           decode = mk(2'h1, 4'h8, CTD_K_SEQ, CTD_T_NONE);
      8'hA4:                           decode = mk(2'h1, 4'h4, CTD_K_SEQ, CTD_T_NONE);
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85: decode = mk(2'h3, 4'h3, CTD_K_SEQ, CTD_T_NONE);
      8'hC0, 8'hD0:                    decode = mk(2'h2, 4'h2, CTD_K_SEQ, CTD_T_NONE);
      8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2, 8'hB0, 8'hB2, 8'hC2, 8'hD2:
                                       decode = mk(2'h2, 4'h2, CTD_K_SEQ, CTD_T_NONE);
      8'h42, 8'h52, 8'h62:             decode = mk(2'h2, 4'h2, CTD_K_SEQ, CTD_T_NONE);
      8'b0111_011?:                    decode = mk(2'h2, 4'h2, CTD_K_SEQ, CTD_T_NONE);
      8'h86, 8'h87, 8'hA6, 8'hA7, 8'b0111_1???, 8'b1000_1???, 8'b1010_1???:
                                       decode = mk(2'h2, 4'h2, CTD_K_SEQ, CTD_T_NONE);
      8'b????_011?:                    decode = mk(2'h1, 4'h2, CTD_K_SEQ, CTD_T_NONE);
      8'b????_1???:                    decode = mk(2'h1, 4'h1, CTD_K_SEQ, CTD_T_NONE);
      8'b????_0101:                    decode = mk(2'h2, 4'h2, CTD_K_SEQ, CTD_T_NONE);
      8'b000?_0100, 8'b11??_0100:      decode = mk(2'h1, 4'h1, CTD_K_SEQ, CTD_T_NONE);
      8'b????_0100:                    decode = mk(2'h2, 4'h2, CTD_K_SEQ, CTD_T_NONE);
      8'b????_0011:                    decode = mk(2'h1, 4'h1, CTD_K_SEQ, CTD_T_NONE);
      default:                         decode = mk(2'h1, 4'h1, CTD_K_SEQ, CTD_T_NONE);
    endcase
  endfunction

  ctd_dec_t           dec;
  logic               accept;
  logic               taken;
  logic               is_cond;
  logic               is_branch;
  logic [7:0]         rel;
  logic [7:0]         cmp_lhs;
  logic [7:0]         cmp_rhs;
  logic [15:0]        seq_pc;
  logic [15:0]        target;
  logic               miss;
  logic [CYC_W-1:0]   cyc_d;
  logic [CYC_W-1:0]   remain_q;
  logic [CYC_W-1:0]   elapsed_q;
  logic               started_q;

  assign dec     = decode(OPCODE);
  assign READY   = (remain_q == '0);
  assign accept  = OPCODE_VALID && READY;
  assign is_cond = dec.kind inside {CTD_K_C, CTD_K_NC, CTD_K_B, CTD_K_NB, CTD_K_BC,
                                    CTD_K_Z, CTD_K_NZ, CTD_K_NE, CTD_K_DJ};
  assign is_branch = (dec.kind != CTD_K_SEQ);
  assign seq_pc  = INSN_PC + {14'h0000, dec.bytes};
  assign rel     = (dec.bytes == 2'h3) ? OPERAND_2 : OPERAND_1;
  assign cmp_lhs = (OPCODE[3:1] == 3'h2) ? ACC : SRC_VALUE;
  assign cmp_rhs = (OPCODE == 8'hB5) ? SRC_VALUE : OPERAND_1;

  always_comb begin
    case (dec.kind)
      CTD_K_JUMP, CTD_K_RET, CTD_K_IND: taken = 1'b1;
      CTD_K_C:  taken = CARRY;
      CTD_K_NC: taken = !CARRY;
      CTD_K_B, CTD_K_BC: taken = BIT_VALUE;
      CTD_K_NB: taken = !BIT_VALUE;
      CTD_K_Z:  taken = (ACC == 8'h00);
      CTD_K_NZ: taken = (ACC != 8'h00);
      CTD_K_NE: taken = (cmp_lhs != cmp_rhs);
      CTD_K_DJ: taken = (SRC_VALUE != `CTD_DECJ_LAST);
      default:  taken = 1'b0;
    endcase
  end

  always_comb begin
    case (dec.tgt)
      CTD_T_REL:  target = seq_pc + {{8{rel[7]}}, rel};
      CTD_T_PAGE: target = {seq_pc[15:`CTD_PAGE_LSB], OPCODE[7:5], OPERAND_1};
      CTD_T_FULL: target = {OPERAND_1, OPERAND_2};
      CTD_T_IND:  target = DATA_POINTER + {8'h00, ACC};
      CTD_T_RET:  target = RET_ADDR;
      default:    target = seq_pc;
    endcase
  end

  assign miss  = is_branch && taken && !BTC_HIT;
  assign cyc_d = CYC_W'(dec.cyc)
               + CYC_W'(is_cond && taken)
               + (miss ? CYC_W'(MISS_PENALTY) : CYC_W'(0));

  // Fetch pacing: next opcode is taken no sooner than cyc_d clocks after this one
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      remain_q <= '0;
    end else if (accept) begin
      remain_q <= cyc_d - CYC_W'(1);
    end else if (remain_q != '0) begin
      remain_q <= remain_q - CYC_W'(1);
    end
  end

  // Length and timing of the instruction last taken
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      INSN_BYTES  <= 2'h0;
      INSN_CYCLES <= '0;
      CACHE_MISS  <= 1'b0;
    end else if (accept) begin
      INSN_BYTES  <= dec.bytes;
      INSN_CYCLES <= cyc_d;
      CACHE_MISS  <= miss;
    end
  end

  // Branch resolution
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      BRANCH_TAKEN  <= 1'b0;
      BRANCH_TARGET <= `CTD_RESET_PC;
      NEXT_PC       <= `CTD_RESET_PC;
      BIT_CLEAR     <= 1'b0;
    end else if (accept) begin
      BRANCH_TAKEN  <= is_branch && taken;
      BRANCH_TARGET <= target;
      NEXT_PC       <= (is_branch && taken) ? target : seq_pc;
      BIT_CLEAR     <= (dec.kind == CTD_K_BC) && BIT_VALUE;
    end
  end

  // Operand addressing and nibble exchange data
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      DIRECT_SPECIAL    <= 1'b0;
      INDIRECT_PTR_ADDR <= 8'h00;
      NIBBLE_ACC        <= 8'h00;
      NIBBLE_RAM        <= 8'h00;
    end else if (accept) begin
      DIRECT_SPECIAL    <= OPERAND_1[`CTD_SPC_SEL_BIT];
      INDIRECT_PTR_ADDR <= {3'h0, BANK_SEL, 2'h0, OPCODE[0]};
      NIBBLE_ACC        <= {ACC[7:4], SRC_VALUE[3:0]};
      NIBBLE_RAM        <= {SRC_VALUE[7:4], ACC[3:0]};
    end
  end

  // Checking helpers: clocks since the last opcode was taken
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      elapsed_q <= '0;
      started_q <= 1'b0;
    end else if (accept) begin
      elapsed_q <= CYC_W'(1);
      started_q <= 1'b1;
    end else if (elapsed_q != '1) begin
      elapsed_q <= elapsed_q + CYC_W'(1);
    end
  end

  sequence s_take(logic [7:0] op);
    accept && (OPCODE == op);
  endsequence

  sequence s_len_cyc(logic [1:0] b, logic [3:0] c);
    (INSN_BYTES == b) && (INSN_CYCLES == CYC_W'(c));
  endsequence

  fetch_spacing_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    started_q && (elapsed_q < INSN_CYCLES) |-> !READY)
    else $error("next fetch allowed before instruction cycles elapsed");

  fetch_return_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    started_q && (elapsed_q == INSN_CYCLES) |-> READY)
    else $error("next fetch not allowed after instruction cycles");

  code_table_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_take(`CTD_OP_CODE_PC) or s_take(`CTD_OP_CODE_DP)) |=> s_len_cyc(2'h1, 4'h3) ##2 READY)
    else $error("code table load timing wrong");

  ext_move_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3})
    |=> s_len_cyc(2'h1, 4'h3) ##0 !READY ##1 !READY ##1 READY)
    else $error("external move timing wrong");

  stack_move_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_take(`CTD_OP_PUSH) or s_take(`CTD_OP_POP)) |=> s_len_cyc(2'h2, 4'h2) ##1 READY)
    else $error("stack move timing wrong");

  nibble_swap_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE[7:1] == 7'h6B) |=> s_len_cyc(2'h1, 4'h2)
    ##0 NIBBLE_ACC == {$past(ACC[7:4]), $past(SRC_VALUE[3:0])}
    ##0 NIBBLE_RAM == {$past(SRC_VALUE[7:4]), $past(ACC[3:0])})
    else $error("low nibble exchange wrong");

  cond_extra_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && is_cond && BTC_HIT |=> INSN_CYCLES == CYC_W'($past(dec.cyc)) + CYC_W'(BRANCH_TAKEN))
    else $error("conditional branch cycle count wrong");

  miss_stall_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_take(`CTD_OP_LONG_JUMP) ##0 !BTC_HIT |=> CACHE_MISS && INSN_CYCLES == CYC_W'(4) + CYC_W'(MISS_PENALTY))
    else $error("miss stall not added");

  rel_target_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_take(`CTD_OP_SHORT_JUMP) |=> BRANCH_TAKEN
    && BRANCH_TARGET == $past(INSN_PC) + 16'h0002 + {{8{$past(OPERAND_1[7])}}, $past(OPERAND_1)})
    else $error("relative target wrong");

  page_target_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE[4:0] == `CTD_OP_PAGE_LOW)
    |=> ((BRANCH_TARGET ^ ($past(INSN_PC) + 16'h0002)) >> `CTD_PAGE_LSB) == 16'h0000
    ##0 BRANCH_TARGET[`CTD_PAGE_LSB-1:0] == {$past(OPCODE[7:5]), $past(OPERAND_1)})
    else $error("page target left its page");

  bit_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_take(`CTD_OP_BIT_CLR_J) |=> BIT_CLEAR == $past(BIT_VALUE) && BRANCH_TAKEN == BIT_CLEAR)
    else $error("test and clear jump wrong");

  unused_nop_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_take(`CTD_OP_UNUSED) |=> s_len_cyc(2'h1, 4'h1) ##0 !BRANCH_TAKEN ##0 READY)
    else $error("unused opcode not a no-operation");

  ptr_load_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_take(`CTD_OP_PTR_LOAD) |=> s_len_cyc(2'h3, 4'h3) ##2 READY)
    else $error("pointer load timing wrong");

  ind_store_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE[7:1] == 7'h3B) |=> s_len_cyc(2'h2, 4'h2) ##1 READY)
    else $error("indirect immediate store timing wrong");

  swap_indirect_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE[7:1] == 7'h63) |=> s_len_cyc(2'h1, 4'h2) ##1 READY)
    else $error("indirect exchange timing wrong");

  swap_register_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE[7:3] == 5'h19) |=> s_len_cyc(2'h1, 4'h1) ##0 READY)
    else $error("register exchange timing wrong");

  bit_ops_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE inside {8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2, 8'hB0, 8'hB2, 8'hC2, 8'hD2})
    |=> s_len_cyc(2'h2, 4'h2) ##1 READY)
    else $error("direct bit operation timing wrong");

  carry_ops_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE inside {8'hB3, 8'hC3, 8'hD3}) |=> s_len_cyc(2'h1, 4'h1) ##0 READY)
    else $error("carry operation timing wrong");

  carry_jump_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE inside {8'h40, 8'h50}) && BTC_HIT |=> INSN_BYTES == 2'h2
    && BRANCH_TAKEN == ($past(OPCODE[4]) ^ $past(CARRY))
    && INSN_CYCLES == (BRANCH_TAKEN ? CYC_W'(3) : CYC_W'(2)))
    else $error("carry jump wrong");

  zero_jump_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE inside {8'h60, 8'h70}) && BTC_HIT |=> INSN_BYTES == 2'h2
    && BRANCH_TAKEN == ($past(OPCODE[4]) ^ ($past(ACC) == 8'h00))
    && INSN_CYCLES == (BRANCH_TAKEN ? CYC_W'(3) : CYC_W'(2)))
    else $error("accumulator zero jump wrong");

  cmp_indirect_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE[7:1] == 7'h5B) && BTC_HIT |=> INSN_BYTES == 2'h3
    && BRANCH_TAKEN == ($past(SRC_VALUE) != $past(OPERAND_1))
    && INSN_CYCLES == (BRANCH_TAKEN ? CYC_W'(5) : CYC_W'(4)))
    else $error("indirect compare jump wrong");

  dec_jump_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE[7:3] == 5'h1B) && BTC_HIT |=> INSN_BYTES == 2'h2
    && BRANCH_TAKEN == ($past(SRC_VALUE) != `CTD_DECJ_LAST)
    && INSN_CYCLES == (BRANCH_TAKEN ? CYC_W'(3) : CYC_W'(2)))
    else $error("register decrement jump wrong");

  long_target_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && (OPCODE inside {8'h02, 8'h12}) |=> NEXT_PC == {$past(OPERAND_1), $past(OPERAND_2)})
    else $error("long target wrong");

  pointer_jump_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_take(8'h73) ##0 BTC_HIT |=> s_len_cyc(2'h1, 4'h3) ##0 NEXT_PC == $past(DATA_POINTER) + {8'h00, $past(ACC)})
    else $error("indirect pointer jump wrong");

endmodule

// [pkg/ctd_consts.svh]
/*
  Constants for the instruction decode and timing block: operand field
  positions, the default cache-miss stall and opcodes the checks refer to.
  Assumes it is included by its bare name after the package.
*/
`ifndef CTD_CONSTS_SVH
`define CTD_CONSTS_SVH

`define CTD_SPC_SEL_BIT   7
`define CTD_PAGE_LSB      11
`define CTD_MISS_PENALTY  4'h2
`define CTD_DECJ_LAST     8'h01
`define CTD_RESET_PC      16'h0000

`define CTD_OP_NOP        8'h00
`define CTD_OP_UNUSED     8'hA5
`define CTD_OP_LONG_JUMP  8'h02
`define CTD_OP_SHORT_JUMP 8'h80
`define CTD_OP_BIT_CLR_J  8'h10
`define CTD_OP_PTR_LOAD   8'h90
`define CTD_OP_CODE_PC    8'h83
`define CTD_OP_CODE_DP    8'h93
`define CTD_OP_PUSH       8'hC0
`define CTD_OP_POP        8'hD0
`define CTD_OP_PAGE_LOW   5'h01

`endif

// [pkg/ctd_pkg.sv]
/*
  Types for the instruction decode and timing block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ctd_pkg;

  typedef enum logic [3:0] {
    CTD_K_SEQ, CTD_K_JUMP, CTD_K_RET, CTD_K_IND,
    CTD_K_C, CTD_K_NC, CTD_K_B, CTD_K_NB, CTD_K_BC,
    CTD_K_Z, CTD_K_NZ, CTD_K_NE, CTD_K_DJ
  } ctd_kind_t;

  typedef enum logic [2:0] {
    CTD_T_NONE, CTD_T_REL, CTD_T_PAGE, CTD_T_FULL, CTD_T_IND, CTD_T_RET
  } ctd_tgt_t;

  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cyc;
    ctd_kind_t  kind;
    ctd_tgt_t   tgt;
  } ctd_dec_t;

endpackage

// [verification/cpu_instruction_timing_decode_tb_top.sv]
/*
  Self-checking bench for the decoder: drives whole instructions through
  the code memory model and measures spacing of READY.
  Assumes a single 50 MHz clock and synchronous active-low reset.
*/
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %0t got %0h want %0h", $time, (g), (e)); \
  end \
end

module cpu_instruction_timing_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ctd_pkg::*;

  localparam int PEN = 2;
  logic sys_clk = 1'b0, rst_n = 1'b0, valid = 1'b0, carry = 1'b0, bitv = 1'b0, hit = 1'b1;
  logic [15:0] insn_pc = 16'h0000, data_pointer = 16'h0000, ret_addr = 16'h0000;
  logic [7:0]  acc = 8'h00, src = 8'h00, op, o1, o2;
  logic [1:0]  bank = 2'h0, bytes;
  logic [3:0]  cycles;
  logic [15:0] tgt, next_pc;
  logic        ready, taken, miss, bclr, dsfr;
  logic [7:0]  iptr, nacc, nram;
  logic [15:0] dp_v = 16'h0000, ra_v = 16'h0000;
  logic [1:0]  bk_v = 2'h0;
  int mismatches = 0, comparisons = 0;

  ctd_code_mem_model mem (.addr(insn_pc), .byte_0(op), .byte_1(o1), .byte_2(o2));

  ctd_decoder #(.CYC_W(4), .MISS_PENALTY(4'h2)) uut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .OPCODE_VALID(valid), .OPCODE(op), .OPERAND_1(o1),
    .OPERAND_2(o2), .INSN_PC(insn_pc), .ACC(acc), .DATA_POINTER(data_pointer), .CARRY(carry),
    .BIT_VALUE(bitv), .SRC_VALUE(src), .RET_ADDR(ret_addr), .BANK_SEL(bank), .BTC_HIT(hit),
    .READY(ready), .INSN_BYTES(bytes), .INSN_CYCLES(cycles), .BRANCH_TAKEN(taken),
    .BRANCH_TARGET(tgt), .NEXT_PC(next_pc), .CACHE_MISS(miss), .BIT_CLEAR(bclr),
    .DIRECT_SPECIAL(dsfr), .INDIRECT_PTR_ADDR(iptr), .NIBBLE_ACC(nacc), .NIBBLE_RAM(nram));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One instruction: load bytes, request, then count clocks until READY returns
  task automatic run(input logic [15:0] pc, input logic [7:0] b0, b1, b2, input logic c, bv,
                     input logic [7:0] a, s, input logic h, output int n);
    mem.put(pc, b0);
    mem.put(pc + 16'h0001, b1);
    mem.put(pc + 16'h0002, b2);
    @(posedge sys_clk);
    insn_pc <= pc; carry <= c; bitv <= bv; acc <= a; src <= s; hit <= h;
    data_pointer <= dp_v; ret_addr <= ra_v; bank <= bk_v; valid <= 1'b1;
    @(posedge sys_clk);
    valid <= 1'b0;
    #1;
    n = 1;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic t_straight();
    logic [15:0] tab [22] = '{16'h9033, 16'h8313, 16'h9313, 16'hE013, 16'hF013, 16'hE213, 16'hF313,
      16'hC022, 16'hD022, 16'hD612, 16'hC612, 16'hC811, 16'h7622, 16'h9222, 16'hB222, 16'h8222,
      16'hA022, 16'hC311, 16'hD311, 16'hB311, 16'hA511, 16'h0011};
    int n;
    foreach (tab[i]) begin
      run(16'h0200, tab[i][15:8], 8'h12, 8'h34, 1'b1, 1'b1, 8'h00, 8'h01, 1'b0, n);
      `CHK(bytes, tab[i][5:4])
      `CHK(cycles, tab[i][3:0])
      `CHK(n, int'(tab[i][3:0]))
      `CHK(taken, 1'b0)
      `CHK(next_pc, 16'h0200 + {14'h0, tab[i][5:4]})
    end
    $display("test straight done");
  endtask

  task automatic t_cond();
    logic [7:0] tab [13] = '{8'h40, 8'h50, 8'h20, 8'h30, 8'h10, 8'h60, 8'h70, 8'hB4, 8'hB5, 8'hBE,
      8'hB6, 8'hD8, 8'hD5};
    logic [7:0] b1, a, s;
    logic c, bv, t;
    int n, nb, base;
    foreach (tab[i]) begin
      for (int k = 0; k < 2; k++) begin
        t = k[0]; b1 = 8'hF0; c = 1'b0; bv = 1'b0; a = 8'h00; s = 8'h00;
        case (tab[i])
          8'h40: c = t;
          8'h50: c = !t;
          8'h20, 8'h10: bv = t;
          8'h30: bv = !t;
          8'h60: a = t ? 8'h00 : 8'h05;
          8'h70: a = t ? 8'h05 : 8'h00;
          8'hB4: begin a = 8'h05; b1 = t ? 8'h06 : 8'h05; end
          8'hB5: begin a = 8'h05; s = t ? 8'h06 : 8'h05; end
          8'hBE, 8'hB6: begin s = 8'h05; b1 = t ? 8'h06 : 8'h05; end
          default: s = t ? 8'h03 : 8'h01;
        endcase
        nb = (tab[i][7:4] inside {4'h4, 4'h5, 4'h6, 4'h7} || tab[i] == 8'hD8) ? 2 : 3;
        base = (tab[i] == 8'hB6) ? 4 : nb;
        // Not-taken runs carry a cache miss, which must not stall them
        run(16'h1000, tab[i], b1, 8'hF0, c, bv, a, s, t, n);
        `CHK(bytes, nb[1:0])
        `CHK(taken, t)
        `CHK(cycles, 4'(base + k))
        `CHK(n, base + k)
        `CHK(miss, 1'b0)
        `CHK(next_pc, t ? 16'(16'h1000 + nb - 16) : 16'(16'h1000 + nb))
        `CHK(tgt, 16'(16'h1000 + nb - 16))
        if (tab[i] == 8'h10) begin
          `CHK(bclr, t)
        end else begin
          `CHK(bclr, 1'b0)
        end
      end
    end
    $display("test conditional done");
  endtask

  task automatic t_uncond();
    logic [7:0] ops [8] = '{8'h80, 8'hE1, 8'hF1, 8'h02, 8'h12, 8'h73, 8'h22, 8'h32};
    logic [15:0] pcs [8] = '{16'h1000, 16'h37FE, 16'h37FE, 16'h5000, 16'h5000, 16'h6000, 16'h7000, 16'h7000};
    logic [15:0] exp [8] = '{16'h1012, 16'h3F34, 16'h3F34, 16'hABCD, 16'hABCD, 16'h1324, 16'h4321, 16'h4321};
    int cyc [8] = '{3, 3, 3, 4, 4, 3, 5, 5};
    logic [7:0] b1;
    int n;
    dp_v = 16'h1234;
    ra_v = 16'h4321;
    foreach (ops[i]) begin
      for (int h = 0; h < 2; h++) begin
        b1 = (ops[i] == 8'h80) ? 8'h10 : ((ops[i][4:0] inside {5'h01, 5'h11}) ? 8'h34 : 8'hAB);
        run(pcs[i], ops[i], b1, 8'hCD, 1'b0, 1'b0, 8'hF0, 8'h00, h[0], n);
        `CHK(taken, 1'b1)
        `CHK(next_pc, exp[i])
        `CHK(tgt, exp[i])
        `CHK(cycles, 4'(cyc[i] + (h == 0 ? PEN : 0)))
        `CHK(n, cyc[i] + (h == 0 ? PEN : 0))
        `CHK(miss, (h == 0))
      end
    end
    $display("test unconditional done");
  endtask

  task automatic t_operands();
    int n;
    bk_v = 2'h2;
    run(16'h0300, 8'hD6, 8'h00, 8'h00, 1'b0, 1'b0, 8'h3C, 8'hA5, 1'b1, n);
    `CHK(nacc, 8'h35)
    `CHK(nram, 8'hAC)
    `CHK(iptr, 8'h10)
    bk_v = 2'h3;
    run(16'h0300, 8'hD7, 8'h00, 8'h00, 1'b0, 1'b0, 8'h3C, 8'hA5, 1'b1, n);
    `CHK(iptr, 8'h19)
    run(16'h0400, 8'hE5, 8'h7F, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, n);
    `CHK(dsfr, 1'b0)
    run(16'h0400, 8'hE5, 8'h80, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, n);
    `CHK(dsfr, 1'b1)
    $display("test operands done");
  endtask

  initial begin
    #500000;
    mismatches++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK(ready, 1'b1)
    `CHK(bytes, 2'h0)
    t_straight();
    t_cond();
    t_uncond();
    t_operands();
    summarize();
  end
endmodule

// [verification/ctd_code_mem_model.sv]
/*
  Behavioural program memory facing the decoder: presents the opcode byte
  and the two bytes after it for the address the fetch side points at.
  Assumes the bench loads bytes through put before it points at them.
*/
module ctd_code_mem_model (
  input  wire logic [15:0] addr,
  output logic      [7:0]  byte_0,
  output logic      [7:0]  byte_1,
  output logic      [7:0]  byte_2
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem_q [0:65535];

  // Unloaded places hold an inverted address pattern, zero only where the two address bytes XOR to 0xFF
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_q[i] = ~(i[7:0] ^ i[15:8]);
    end
  end

  task automatic put(input logic [15:0] a, input logic [7:0] b);
    mem_q[a] = b;
  endtask

  assign byte_0 = mem_q[addr];
  assign byte_1 = mem_q[addr + 16'h0001];
  assign byte_2 = mem_q[addr + 16'h0002];
endmodule
